// ==== src/qcpm_pkg.sv ====
// shared constants, types and decode functions for the quad channel pin mux
package qcpm_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_CHAN   = 4;
  localparam int NUM_LINES  = 8;
  localparam int ENG_CHANS  = 2;
  localparam int ALL_LINES  = NUM_CHAN * NUM_LINES;

  // ==========================================================================
  // channel modes
  typedef enum logic [1:0] {
    QCPM_MODE_UART     = 2'h0,
    QCPM_MODE_BB_SYNC  = 2'h1,
    QCPM_MODE_BB_ASYNC = 2'h2,
    QCPM_MODE_ENGINE   = 2'h3
  } qcpm_mode_t;

  // configuration load sequence, one-hot
  typedef enum logic [1:0] {
    QCPM_CFG_WAIT = 2'b01,
    QCPM_CFG_DONE = 2'b10
  } qcpm_cfg_state_t;

  // ==========================================================================
  // line positions inside a channel, uart function
  localparam int LN_TXD  = 0;
  localparam int LN_RXD  = 1;
  localparam int LN_RTS  = 2;
  localparam int LN_CTS  = 3;
  localparam int LN_DTR  = 4;
  localparam int LN_DSR  = 5;
  localparam int LN_DCD  = 6;
  localparam int LN_RI   = 7;
  // line positions, serial engine function
  localparam int LN_ECLK = 0;
  localparam int LN_EDO  = 1;
  localparam int LN_EDI  = 2;
  localparam int LN_ESEL = 3;
  localparam int LN_EGP  = 4;

  // ==========================================================================
  // values after reset
  localparam logic [1:0]          MODE_RST      = 2'h0;
  localparam logic [NUM_CHAN-1:0] DRIVE_SEL_RST = 4'h0;
  localparam logic [NUM_CHAN-1:0] UART_IN_RST   = 4'hf;
  localparam logic [NUM_CHAN-1:0] SYNC_SEL_RST  = 4'h0;
  localparam logic [ENG_CHANS-1:0] ENG_DIN_RST  = 2'h0;
  localparam logic [4*ENG_CHANS-1:0] ENG_GP_RST = 8'h00;
  localparam logic                WAKE_RST      = 1'h0;
  localparam logic [NUM_CHAN-1:0] WAKE_EN_RST   = 4'h0;
  localparam logic                PULLDOWN_RST  = 1'h0;
  localparam logic [ALL_LINES-1:0] PAD_RST      = 32'h0;
  localparam logic [ALL_LINES-1:0] PAD_IN_RST   = 32'hffffffff;

  // engine exists only on the first two channels; a request elsewhere falls
  // back to uart rather than leaving the pins undriven
  function automatic logic [1:0] eff_mode(input int chan, input logic [1:0] req);
    if (chan >= ENG_CHANS && req == QCPM_MODE_ENGINE) begin
      return QCPM_MODE_UART;
    end
    return req;
  endfunction : eff_mode

  function automatic logic is_uart(input logic [1:0] m);
    return m == QCPM_MODE_UART;
  endfunction : is_uart

endpackage : qcpm_pkg

// ==== src/qcpm_chan_mux.sv ====
// per channel line function selector, purely combinational
`timescale 1ns/1ns
module qcpm_chan_mux (
  input  wire logic [1:0] mode,
  input  wire logic       loaded,
  input  wire logic       drive_sel,
  input  wire logic       uart_txd,
  input  wire logic       uart_rts_n,
  input  wire logic       uart_dtr_n,
  input  wire logic       drive_en,
  input  wire logic [7:0] bb_out,
  input  wire logic [7:0] bb_oe,
  input  wire logic       clk_out,
  input  wire logic       data_out,
  input  wire logic       select_out,
  input  wire logic [3:0] gp_out,
  input  wire logic [3:0] gp_oe,
  output logic      [7:0] line_out,
  output logic      [7:0] line_oe
);

  always_comb begin
    line_out = 8'h00;
    line_oe  = 8'h00;
    unique case (mode)
      qcpm_pkg::QCPM_MODE_UART: begin
        line_out[qcpm_pkg::LN_TXD] = uart_txd;
        line_oe[qcpm_pkg::LN_TXD]  = 1'b1;
        line_out[qcpm_pkg::LN_RTS] = uart_rts_n;
        line_oe[qcpm_pkg::LN_RTS]  = 1'b1;
        line_out[qcpm_pkg::LN_DTR] = uart_dtr_n;
        line_oe[qcpm_pkg::LN_DTR]  = 1'b1;
        // eighth line is either ring input or rs485 driver enable
        line_out[qcpm_pkg::LN_RI]  = drive_en;
        line_oe[qcpm_pkg::LN_RI]   = drive_sel;
      end
      qcpm_pkg::QCPM_MODE_BB_SYNC, qcpm_pkg::QCPM_MODE_BB_ASYNC: begin
        line_out = bb_out;
        line_oe  = bb_oe;
      end
      qcpm_pkg::QCPM_MODE_ENGINE: begin
        line_out[qcpm_pkg::LN_ECLK] = clk_out;
        line_oe[qcpm_pkg::LN_ECLK]  = 1'b1;
        line_out[qcpm_pkg::LN_EDO]  = data_out;
        line_oe[qcpm_pkg::LN_EDO]   = 1'b1;
        line_out[qcpm_pkg::LN_ESEL] = select_out;
        line_oe[qcpm_pkg::LN_ESEL]  = 1'b1;
        line_out[7:4]               = gp_out;
        line_oe[7:4]                = gp_oe;
      end
    endcase
    // nothing drives a pad until the configuration is known
    if (!loaded) begin
      line_oe = 8'h00;
    end
  end

endmodule : qcpm_chan_mux

// ==== src/qcpm_pin_mux.sv ====
// quad channel pin mux: uart, bit-bang and serial engine line selection
`timescale 1ns/1ns
// What this block does
// - Any of four channels works as uart with txd, rxd, handshake and modem lines.
// - In uart mode with wake enabled, ring line low asks the suspended host to resume.
// - With suspend pull-down enabled, the ring line never causes a wake.
// - Eighth uart line is ring input or rs485 driver enable output.
// - That choice comes from stored configuration; default is ring input.
// - Every channel supports sync or async bit-bang, chosen per channel.
// - In bit-bang all eight lines are individually bidirectional data.
// - Only channels a and b have a serial engine, each configured alone.
// - Engine mode: line 0 is the clock output.
// - Engine mode: line 1 is serial data output.
// - Engine mode: line 2 is serial data input.
// - Engine mode: line 3 is the select output.
// - Engine mode: lines 4 to 7 are general purpose bidirectional lines.
// - Channels c and d stay uart or bit-bang whatever a and b use.
module qcpm_pin_mux (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // configuration from the memory reader
  input  wire logic        cfg_load_valid,
  input  wire logic [7:0]  cfg_mode,
  input  wire logic [3:0]  cfg_drive_en_sel,
  input  wire logic [3:0]  cfg_remote_wake,
  input  wire logic        cfg_suspend_pulldown,
  input  wire logic        usb_suspended,
  // pads, eight lines per channel, channel a in the low byte
  input  wire logic [31:0] pad_in,
  output logic      [31:0] pad_out,
  output logic      [31:0] pad_oe,
  // uart side
  input  wire logic [3:0]  uart_txd,
  input  wire logic [3:0]  uart_rts_n,
  input  wire logic [3:0]  uart_dtr_n,
  input  wire logic [3:0]  rs485_drive_enable,
  output logic      [3:0]  uart_rxd,
  output logic      [3:0]  uart_cts_n,
  output logic      [3:0]  uart_dsr_n,
  output logic      [3:0]  carrier_detect_n,
  output logic      [3:0]  ring_indicator_n,
  // bit-bang side
  input  wire logic [31:0] bb_out,
  input  wire logic [31:0] bb_oe,
  output logic      [31:0] bb_in,
  output logic      [3:0]  bb_sync_sel,
  // serial engine side, channels a and b
  input  wire logic [1:0]  engine_clock_out,
  input  wire logic [1:0]  engine_data_out,
  input  wire logic [1:0]  engine_select_out,
  input  wire logic [7:0]  engine_gp_out,
  input  wire logic [7:0]  engine_gp_oe,
  output logic      [1:0]  engine_data_in,
  output logic      [7:0]  engine_gp_in,
  // status
  output logic      [7:0]  active_mode,
  output logic             cfg_loaded,
  output logic             wake_request
);

  // ==========================================================================
  // state
  qcpm_pkg::qcpm_cfg_state_t state_q, state_d;
  logic [7:0]  mode_q, mode_d;
  logic [3:0]  drive_sel_q, drive_sel_d;
  logic [3:0]  wake_en_q, wake_en_d;
  logic        pulldown_q, pulldown_d;
  logic [31:0] meta_q, sync_q;
  logic [31:0] pad_out_q, pad_out_d, pad_oe_q, pad_oe_d;
  logic [31:0] mux_out, mux_oe;
  logic [3:0]  rxd_q, rxd_d, cts_q, cts_d, dsr_q, dsr_d;
  logic [3:0]  dcd_q, dcd_d, ri_q, ri_d, bbs_q, bbs_d;
  logic [31:0] bb_in_q;
  logic [1:0]  edi_q, edi_d;
  logic [7:0]  egp_q, egp_d;
  logic        wake_q, wake_d;
  logic        loaded;

  assign loaded = state_q == qcpm_pkg::QCPM_CFG_DONE;

  // ==========================================================================
  // per channel line selection
  genvar c;
  generate
    for (c = 0; c < qcpm_pkg::NUM_CHAN; c++) begin : g_chan
      localparam int E = (c < qcpm_pkg::ENG_CHANS) ? c : 0;
      logic eng_ok;
      assign eng_ok = c < qcpm_pkg::ENG_CHANS;
      qcpm_chan_mux u_mux (
        .mode       (mode_q[2*c +: 2]),
        .loaded     (loaded),
        .drive_sel  (drive_sel_q[c]),
        .uart_txd   (uart_txd[c]),
        .uart_rts_n (uart_rts_n[c]),
        .uart_dtr_n (uart_dtr_n[c]),
        .drive_en   (rs485_drive_enable[c]),
        .bb_out     (bb_out[8*c +: 8]),
        .bb_oe      (bb_oe[8*c +: 8]),
        .clk_out    (engine_clock_out[E] & eng_ok),
        .data_out   (engine_data_out[E] & eng_ok),
        .select_out (engine_select_out[E] & eng_ok),
        .gp_out     (engine_gp_out[4*E +: 4] & {4{eng_ok}}),
        .gp_oe      (engine_gp_oe[4*E +: 4] & {4{eng_ok}}),
        .line_out   (mux_out[8*c +: 8]),
        .line_oe    (mux_oe[8*c +: 8])
      );
    end
  endgenerate

  // ==========================================================================
  // next values
  always_comb begin
    logic [1:0] m;
    logic       uart_on;
    m           = 2'h0;
    uart_on     = 1'b0;
    state_d     = state_q;
    mode_d      = mode_q;
    drive_sel_d = drive_sel_q;
    wake_en_d   = wake_en_q;
    pulldown_d  = pulldown_q;
    wake_d      = 1'b0;
    if (state_q == qcpm_pkg::QCPM_CFG_WAIT && cfg_load_valid) begin
      state_d     = qcpm_pkg::QCPM_CFG_DONE;
      drive_sel_d = cfg_drive_en_sel;
      wake_en_d   = cfg_remote_wake;
      pulldown_d  = cfg_suspend_pulldown;
      for (int i = 0; i < qcpm_pkg::NUM_CHAN; i++) begin
        mode_d[2*i +: 2] = qcpm_pkg::eff_mode(i, cfg_mode[2*i +: 2]);
      end
    end
    pad_out_d = mux_out;
    pad_oe_d  = mux_oe;
    for (int i = 0; i < qcpm_pkg::NUM_CHAN; i++) begin
      m       = mode_q[2*i +: 2];
      uart_on = loaded && qcpm_pkg::is_uart(m);
      // inputs of an idle uart read as the inactive level
      rxd_d[i] = uart_on ? sync_q[8*i+qcpm_pkg::LN_RXD] : 1'b1;
      cts_d[i] = uart_on ? sync_q[8*i+qcpm_pkg::LN_CTS] : 1'b1;
      dsr_d[i] = uart_on ? sync_q[8*i+qcpm_pkg::LN_DSR] : 1'b1;
      dcd_d[i] = uart_on ? sync_q[8*i+qcpm_pkg::LN_DCD] : 1'b1;
      ri_d[i]  = (uart_on && !drive_sel_q[i]) ? sync_q[8*i+qcpm_pkg::LN_RI] : 1'h1;
      bbs_d[i] = loaded && m == qcpm_pkg::QCPM_MODE_BB_SYNC;
      if (uart_on && !drive_sel_q[i] && wake_en_q[i] && !sync_q[8*i+qcpm_pkg::LN_RI]) begin
        wake_d = usb_suspended && !pulldown_q;
      end
    end
    for (int i = 0; i < qcpm_pkg::ENG_CHANS; i++) begin
      m          = mode_q[2*i +: 2];
      uart_on    = loaded && m == qcpm_pkg::QCPM_MODE_ENGINE;
      edi_d[i]   = uart_on & sync_q[8*i+qcpm_pkg::LN_EDI];
      egp_d[4*i +: 4] = uart_on ? sync_q[8*i+qcpm_pkg::LN_EGP +: 4] : 4'h0;
    end
  end

  // ==========================================================================
  // registers; pads pass two flops before any logic reads them
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q     <= qcpm_pkg::QCPM_CFG_WAIT;
      mode_q      <= {4{qcpm_pkg::MODE_RST}};
      drive_sel_q <= qcpm_pkg::DRIVE_SEL_RST;
      wake_en_q   <= qcpm_pkg::WAKE_EN_RST;
      pulldown_q  <= qcpm_pkg::PULLDOWN_RST;
      meta_q      <= qcpm_pkg::PAD_IN_RST;
      sync_q      <= qcpm_pkg::PAD_IN_RST;
      pad_out_q   <= qcpm_pkg::PAD_RST;
      pad_oe_q    <= qcpm_pkg::PAD_RST;
      rxd_q       <= qcpm_pkg::UART_IN_RST;
      cts_q       <= qcpm_pkg::UART_IN_RST;
      dsr_q       <= qcpm_pkg::UART_IN_RST;
      dcd_q       <= qcpm_pkg::UART_IN_RST;
      ri_q        <= qcpm_pkg::UART_IN_RST;
      bbs_q       <= qcpm_pkg::SYNC_SEL_RST;
      bb_in_q     <= qcpm_pkg::PAD_IN_RST;
      edi_q       <= qcpm_pkg::ENG_DIN_RST;
      egp_q       <= qcpm_pkg::ENG_GP_RST;
      wake_q      <= qcpm_pkg::WAKE_RST;
    end else begin
      state_q     <= state_d;
      mode_q      <= mode_d;
      drive_sel_q <= drive_sel_d;
      wake_en_q   <= wake_en_d;
      pulldown_q  <= pulldown_d;
      meta_q      <= pad_in;
      sync_q      <= meta_q;
      pad_out_q   <= pad_out_d;
      pad_oe_q    <= pad_oe_d;
      rxd_q       <= rxd_d;
      cts_q       <= cts_d;
      dsr_q       <= dsr_d;
      dcd_q       <= dcd_d;
      ri_q        <= ri_d;
      bbs_q       <= bbs_d;
      bb_in_q     <= sync_q;
      edi_q       <= edi_d;
      egp_q       <= egp_d;
      wake_q      <= wake_d;
    end
  end

  assign pad_out          = pad_out_q;
  assign pad_oe           = pad_oe_q;
  assign uart_rxd         = rxd_q;
  assign uart_cts_n       = cts_q;
  assign uart_dsr_n       = dsr_q;
  assign carrier_detect_n = dcd_q;
  assign ring_indicator_n = ri_q;
  assign bb_in            = bb_in_q;
  assign bb_sync_sel      = bbs_q;
  assign engine_data_in   = edi_q;
  assign engine_gp_in     = egp_q;
  assign active_mode      = mode_q;
  // done bit of the one-hot state, so the status leaves straight from a flop
  assign cfg_loaded       = state_q[1];
  assign wake_request     = wake_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  no_drive_early_a: assert property (!loaded |=> pad_oe_q == 32'h0)
    else $error("pad driven before configuration load");
  uart_lines_a: assert property (loaded && mode_q[1:0] == 2'h0 |=>
      pad_oe_q[0] && pad_oe_q[2] && pad_out_q[0] == $past(uart_txd[0]))
    else $error("uart transmit line not routed");
  ring_wake_a: assert property (loaded && mode_q[1:0] == 2'h0 && !drive_sel_q[0]
      && wake_en_q[0] && !pulldown_q && usb_suspended && !sync_q[7] |=> wake_q)
    else $error("ring line low did not request wake");
  pulldown_block_a: assert property (pulldown_q |=> !wake_q)
    else $error("wake requested with suspend pull-down");
  drive_enable_a: assert property (loaded && mode_q[1:0] == 2'h0 && drive_sel_q[0] |=>
      pad_oe_q[7] && pad_out_q[7] == $past(rs485_drive_enable[0]))
    else $error("rs485 drive enable not on eighth line");
  ring_default_a: assert property (!loaded |-> drive_sel_q == qcpm_pkg::DRIVE_SEL_RST)
    else $error("eighth line default is not ring input");
  bitbang_bidir_a: assert property (loaded && mode_q[5:4] inside {2'h1, 2'h2} |=>
      pad_oe_q[23:16] == $past(bb_oe[23:16]))
    else $error("bit-bang enables not passed through");
  engine_pins_a: assert property (loaded && mode_q[1:0] == 2'h3 |=>
      pad_oe_q[3:0] == 4'hb && pad_out_q[0] == $past(engine_clock_out[0]))
    else $error("engine clock, data and select lines wrong");
  no_engine_cd_a: assert property (mode_q[5:4] != 2'h3 && mode_q[7:6] != 2'h3)
    else $error("engine mode on channel without engine");
  mode_frozen_a: assert property (loaded |=> $stable(mode_q))
    else $error("mode changed after load");

endmodule : qcpm_pin_mux

// ==== sim/qcpm_periph.sv ====
// far side model: serial peripherals and level converters on the 32 pad lines
`timescale 1ns/1ns
module qcpm_periph (
  input  wire logic [31:0] pad_out,
  input  wire logic [31:0] pad_oe,
  input  wire logic [31:0] drv,
  input  wire logic [31:0] drv_en,
  output logic      [31:0] pad_in
);
  // ==========================================================================
  // wire resolution
  // the peripheral only drives lines the device has released, so it never fights
  // a device output; a line nobody drives sits at the board pull-up
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (drv_en[i]) begin
        pad_in[i] = drv[i];
      end else begin
        pad_in[i] = 1'h1;
      end
    end
  end
endmodule : qcpm_periph

// ==== sim/testbench.sv ====
// self-checking testbench for the quad channel pin mux
`timescale 1ns/1ns
module testbench;
  // ==========================================================================
  // signals
  logic        core_clk, rstn, cfg_load_valid, cfg_suspend_pulldown, usb_suspended;
  logic        cfg_loaded, wake_request, ring_low;
  logic [1:0]  engine_clock_out, engine_data_out, engine_select_out, engine_data_in;
  logic [3:0]  cfg_drive_en_sel, cfg_remote_wake, uart_txd, uart_rts_n, uart_dtr_n;
  logic [3:0]  rs485_drive_enable, uart_rxd, uart_cts_n, uart_dsr_n, carrier_detect_n;
  logic [3:0]  ring_indicator_n, bb_sync_sel;
  logic [7:0]  cfg_mode, engine_gp_out, engine_gp_oe, engine_gp_in, active_mode;
  logic [11:0] saved;
  logic [31:0] pad_in, pad_out, pad_oe, bb_out, bb_oe, bb_in, drv, drv_en, seed, r;
  int          errors, samples_checked;

  qcpm_pin_mux dut (
    .core_clk(core_clk), .rstn(rstn), .cfg_load_valid(cfg_load_valid), .cfg_mode(cfg_mode),
    .cfg_drive_en_sel(cfg_drive_en_sel), .cfg_remote_wake(cfg_remote_wake),
    .cfg_suspend_pulldown(cfg_suspend_pulldown), .usb_suspended(usb_suspended),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .uart_txd(uart_txd),
    .uart_rts_n(uart_rts_n), .uart_dtr_n(uart_dtr_n), .rs485_drive_enable(rs485_drive_enable),
    .uart_rxd(uart_rxd), .uart_cts_n(uart_cts_n), .uart_dsr_n(uart_dsr_n),
    .carrier_detect_n(carrier_detect_n), .ring_indicator_n(ring_indicator_n),
    .bb_out(bb_out), .bb_oe(bb_oe), .bb_in(bb_in), .bb_sync_sel(bb_sync_sel),
    .engine_clock_out(engine_clock_out), .engine_data_out(engine_data_out),
    .engine_select_out(engine_select_out), .engine_gp_out(engine_gp_out),
    .engine_gp_oe(engine_gp_oe), .engine_data_in(engine_data_in), .engine_gp_in(engine_gp_in),
    .active_mode(active_mode), .cfg_loaded(cfg_loaded), .wake_request(wake_request)
  );

  qcpm_periph far_side (
    .pad_out(pad_out), .pad_oe(pad_oe), .drv(drv), .drv_en(drv_en), .pad_in(pad_in)
  );

  // ==========================================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic void predict(output logic [31:0] eo, ev, lv, output logic [19:0] uin,
                                  output logic [7:0] am, output logic [3:0] sy,
                                  output logic [9:0] ein, output logic w);
    logic [1:0] m;
    logic [7:0] o, e;
    logic       u;
    w = 1'h0;
    ein = 10'h0;
    for (int c = 0; c < 4; c++) begin
      // an engine request on c or d falls back to uart
      m = (c >= 2 && cfg_mode[2*c+:2] == 2'h3) ? 2'h0 : cfg_mode[2*c+:2];
      am[2*c+:2] = m;
      sy[c] = (m == 2'h1);
      case (m)
        2'h0: begin
          o = {rs485_drive_enable[c], 2'h3, uart_dtr_n[c], 1'h1, uart_rts_n[c], 1'h1,
               uart_txd[c]};
          e = {cfg_drive_en_sel[c], 7'h15};
        end
        2'h3: begin
          o = {engine_gp_out[4*c+:4], engine_select_out[c], 1'h0, engine_data_out[c],
               engine_clock_out[c]};
          e = {engine_gp_oe[4*c+:4], 4'hb};
        end
        default: begin
          o = bb_out[8*c+:8];
          e = bb_oe[8*c+:8];
        end
      endcase
      eo[8*c+:8] = e;
      ev[8*c+:8] = o & e;
      lv[8*c+:8] = (o & e) | (~e & (drv[8*c+:8] | ~drv_en[8*c+:8]));
      u = (m == 2'h0);
      uin[16+c] = u ? lv[8*c+1] : 1'h1;
      uin[12+c] = u ? lv[8*c+3] : 1'h1;
      uin[8+c] = u ? lv[8*c+5] : 1'h1;
      uin[4+c] = u ? lv[8*c+6] : 1'h1;
      uin[c] = (u && !cfg_drive_en_sel[c]) ? lv[8*c+7] : 1'h1;
      if (m == 2'h3) begin
        ein[8+c] = lv[8*c+2];
        ein[4*c+:4] = lv[8*c+4+:4];
      end
      if (!uin[c] && cfg_remote_wake[c] && usb_suspended && !cfg_suspend_pulldown) begin
        w = 1'h1;
      end
    end
  endfunction : predict

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic check_all();
    logic [31:0] eo, ev, lv;
    logic [19:0] uin;
    logic [9:0]  ein;
    logic [7:0]  am;
    logic [3:0]  sy;
    logic        w;
    logic [19:0] useen;
    predict(eo, ev, lv, uin, am, sy, ein, w);
    useen = {uart_rxd, uart_cts_n, uart_dsr_n, carrier_detect_n, ring_indicator_n};
    cmp("pad_oe", eo, pad_oe);
    cmp("pad_out", ev, pad_out & eo);
    cmp("active_mode", 32'(am), 32'(active_mode));
    cmp("uart_in", 32'(uin), 32'(useen));
    cmp("bb_in", lv, bb_in);
    cmp("bb_sync_sel", 32'(sy), 32'(bb_sync_sel));
    cmp("engine_in", 32'(ein), 32'({engine_data_in, engine_gp_in}));
    cmp("wake_request", 32'(w), 32'(wake_request));
    cmp("cfg_loaded", 32'h1, 32'(cfg_loaded));
  endtask : check_all

  // new function and far side values, then wait out the sync and output flops
  task automatic rand_inputs();
    @(negedge core_clk);
    {uart_txd, uart_rts_n, uart_dtr_n, rs485_drive_enable, engine_gp_out, engine_gp_oe} = xs();
    r = xs();
    {engine_clock_out, engine_data_out, engine_select_out, usb_suspended} = r[6:0];
    bb_out = xs();
    bb_oe = xs();
    drv = xs();
    drv_en = xs();
    if (ring_low) begin
      drv[7] = 1'h0;
      drv_en[7] = 1'h1;
      usb_suspended = 1'h1;
    end
    repeat (6) @(negedge core_clk);
    check_all();
  endtask : rand_inputs

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // clock, watchdog, sequence
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    test_done();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    seed = 32'hbe86;
    {rstn, cfg_load_valid, cfg_suspend_pulldown, usb_suspended, ring_low} = 5'h0;
    {cfg_mode, cfg_drive_en_sel, cfg_remote_wake, uart_txd, uart_rts_n, uart_dtr_n} = 28'h0;
    {rs485_drive_enable, engine_gp_out, engine_gp_oe} = 20'h0;
    {engine_clock_out, engine_data_out, engine_select_out} = 6'h0;
    {bb_out, bb_oe, drv, drv_en} = 128'h0;
    for (int t = 0; t < 24; t++) begin
      rstn = 1'h0;
      repeat (3) @(negedge core_clk);
      r = xs();
      {cfg_mode, cfg_drive_en_sel, cfg_remote_wake, cfg_suspend_pulldown} = r[16:0];
      case (t)
        0: cfg_mode = 8'hff;
        1: cfg_mode = 8'h55;
        2: cfg_mode = 8'haa;
        3, 4: begin
          cfg_mode = 8'h00;
          cfg_drive_en_sel = 4'h0;
          cfg_remote_wake = 4'hf;
          cfg_suspend_pulldown = (t == 4);
        end
        5: cfg_mode = 8'h9f;
        default: ;
      endcase
      ring_low = (t == 3 || t == 4);
      rstn = 1'h1;
      @(negedge core_clk);
      cmp("pad_oe_unloaded", 32'h0, pad_oe);
      cmp("cfg_loaded_unloaded", 32'h0, 32'(cfg_loaded));
      cfg_load_valid = 1'h1;
      @(negedge core_clk);
      cfg_load_valid = 1'h0;
      @(negedge core_clk);
      // a second load with the mode and drive enable select fields inverted must be ignored
      saved = {cfg_mode, cfg_drive_en_sel};
      {cfg_mode, cfg_drive_en_sel} = ~saved;
      cfg_load_valid = 1'h1;
      @(negedge core_clk);
      cfg_load_valid = 1'h0;
      {cfg_mode, cfg_drive_en_sel} = saved;
      for (int k = 0; k < 4; k++) begin
        rand_inputs();
      end
      $display("test %0d done, mode %h", t, cfg_mode);
    end
    test_done();
  end
endmodule : testbench
